/* File: rtl/stc_pkg.sv */
// package: register map, field layout and shared types of the timer
package stc_pkg;

	// -----------------------------------------------------------------
	// register byte addresses
	// -----------------------------------------------------------------
	localparam logic [7:0] STC_ADDR_COUNT_LOW = 8'h00;
	localparam logic [7:0] STC_ADDR_COUNT_HIGH = 8'h04;
	localparam logic [7:0] STC_ADDR_FLAG = 8'h08;
	localparam logic [7:0] STC_ADDR_ENABLE = 8'h0c;
	localparam logic [7:0] STC_ADDR_CONTROL = 8'h10;
	localparam logic [7:0] STC_ADDR_PORT_DIR = 8'h14;
	localparam logic [7:0] STC_ADDR_PORT_EFF = 8'h18;

	// -----------------------------------------------------------------
	// field positions and reset values
	// -----------------------------------------------------------------
	localparam int STC_CTL_RUN = 0;
	localparam int STC_CTL_SRC = 1;
	localparam int STC_CTL_ASYNC = 2;
	localparam int STC_CTL_OSC = 3;
	localparam int STC_CTL_PRE_LO = 4;
	localparam int STC_FLAG_OVF = 0;
	localparam int STC_IE_OVF = 0;
	localparam logic [7:0] STC_CONTROL_RST = 8'h00;
	localparam logic [7:0] STC_PORT_DIR_RST = 8'hff;
	localparam logic [7:0] STC_COUNT_RST = 8'h00;
	localparam logic [15:0] STC_COUNT_MAX = 16'hffff;
	localparam logic [7:0] STC_LATE_FORCE = 8'h03;
	localparam logic [7:0] STC_EARLY_FORCE = 8'h02;

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int STC_CLK_HZ = 20000000;
	localparam logic [1:0] STC_QPHASE_LAST = 2'h3;
	localparam logic [2:0] STC_PRE_CNT_RST = 3'h0;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef enum logic [6:0] {
		STC_SEL_NONE = 7'h00,
		STC_SEL_LOW = 7'h01,
		STC_SEL_HIGH = 7'h02,
		STC_SEL_FLAG = 7'h04,
		STC_SEL_IE = 7'h08,
		STC_SEL_CTL = 7'h10,
		STC_SEL_DIR = 7'h20,
		STC_SEL_EFF = 7'h40
	} stc_sel_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} stc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} stc_apb_rsp_t;

	typedef struct packed {
		logic [7:0] cnt_hi;
		logic [7:0] cnt_lo;
		logic ovf_flag;
		logic ovf_ie;
		logic [7:0] ctrl;
		logic [7:0] dir;
		logic [7:0] dir_eff;
		logic [1:0] qphase;
		logic [31:0] rdata;
		logic rd_err;
	} stc_state_t;

endpackage : stc_pkg

/* File: rtl/stc_edge_detect.sv */
// rising edge detector for the external count input
`timescale 1ns/10ps
`default_nettype none
module stc_edge_detect import stc_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// level in, pulse out
	input wire logic level,
	output logic rise
);

	typedef struct packed {
		logic prev;
	} stc_edge_state_t;

	stc_edge_state_t st_ff;
	stc_edge_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.prev = level;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// pin is synchronous; one stage of history is enough
	assign rise = ce & level & ~st_ff.prev;

endmodule : stc_edge_detect
`default_nettype wire

/* File: rtl/stc_prescaler.sv */
// programmable 1:1..1:8 prescaler on the selected count source
`timescale 1ns/10ps
`default_nettype none
module stc_prescaler import stc_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// control
	input wire logic [1:0] ratio,
	input wire logic clear,
	// ticks
	input wire logic tick_in,
	output logic tick_out
);

	typedef struct packed {
		logic [2:0] cnt;
	} stc_pre_state_t;

	stc_pre_state_t st_ff;
	stc_pre_state_t nxt_st;
	logic [2:0] last;

	assign last = 3'(({1'b0, 2'h0} + 3'h1 << ratio) - 3'h1);
	assign tick_out = ce & tick_in & ~clear & (st_ff.cnt == last);

	always_comb begin
		nxt_st = st_ff;
		if (clear) begin
			nxt_st.cnt = STC_PRE_CNT_RST;
		end else if (tick_in) begin
			if (st_ff.cnt >= last) begin
				nxt_st.cnt = STC_PRE_CNT_RST;
			end else begin
				nxt_st.cnt = st_ff.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

endmodule : stc_prescaler
`default_nettype wire

/* File: rtl/stc_timer.sv */
// sixteen-bit timer/counter with apb registers and overflow interrupt
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module stc_timer import stc_pkg::*; #(
	parameter bit LATE_VARIANT = 1'b1
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// apb slave
	input wire stc_apb_req_t apb_req,
	output stc_apb_rsp_t apb_rsp,
	// external count input and sleep state
	input wire logic ext_clk_in,
	input wire logic sleep_mode,
	// resets from the capture/compare units
	input wire logic ccp_a_reset,
	input wire logic ccp_b_reset,
	// outputs
	output logic irq,
	output logic wake_req,
	output logic [15:0] count_value,
	output logic [7:0] port_c_dir_eff
);

	// -----------------------------------------------------------------
	// address decode
	// -----------------------------------------------------------------
	function automatic stc_sel_t stc_decode(input logic [7:0] addr);
		stc_sel_t sel;
		sel = STC_SEL_NONE;
		if (addr == STC_ADDR_COUNT_LOW) begin
			sel = STC_SEL_LOW;
		end else if (addr == STC_ADDR_COUNT_HIGH) begin
			sel = STC_SEL_HIGH;
		end else if (addr == STC_ADDR_FLAG) begin
			sel = STC_SEL_FLAG;
		end else if (addr == STC_ADDR_ENABLE) begin
			sel = STC_SEL_IE;
		end else if (addr == STC_ADDR_CONTROL) begin
			sel = STC_SEL_CTL;
		end else if (addr == STC_ADDR_PORT_DIR) begin
			sel = STC_SEL_DIR;
		end else if (addr == STC_ADDR_PORT_EFF) begin
			sel = STC_SEL_EFF;
		end
		return sel;
	endfunction : stc_decode

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	stc_state_t st_ff;
	stc_state_t nxt_st;

	stc_sel_t setup_sel;
	stc_sel_t acc_sel;
	logic setup_phase;
	logic acc_phase;
	logic wr_lo;
	logic wr_hi;
	logic wr_cnt;
	logic rd_flag;
	logic ext_rise;
	logic inst_tick;
	logic src_tick;
	logic src_allowed;
	logic pre_in;
	logic pre_tick;
	logic ccp_reset;
	logic [15:0] cnt_now;
	logic [15:0] cnt_inc;
	logic ovf_event;
	logic [7:0] force_mask;
	logic [7:0] wbyte;

	// -----------------------------------------------------------------
	// bus phases
	// -----------------------------------------------------------------
	assign setup_phase = apb_req.psel & ~apb_req.penable;
	assign acc_phase = ce & apb_req.psel & apb_req.penable;
	assign setup_sel = stc_decode(apb_req.paddr);
	assign acc_sel = stc_decode(apb_req.paddr);
	assign wbyte = apb_req.pwdata[7:0];
	assign wr_lo = acc_phase & apb_req.pwrite & apb_req.pstrb[0]
		& (acc_sel == STC_SEL_LOW);
	assign wr_hi = acc_phase & apb_req.pwrite & apb_req.pstrb[0]
		& (acc_sel == STC_SEL_HIGH);
	assign wr_cnt = wr_lo | wr_hi;
	assign rd_flag = acc_phase & ~apb_req.pwrite & (acc_sel == STC_SEL_FLAG);

	// zero wait states; a frozen block holds the bus off
	assign apb_rsp.pready = ce;
	assign apb_rsp.prdata = st_ff.rdata;
	assign apb_rsp.pslverr = acc_phase & (st_ff.rd_err
		| (apb_req.pwrite & (acc_sel == STC_SEL_EFF)));

	// -----------------------------------------------------------------
	// count sources
	// -----------------------------------------------------------------
	stc_edge_detect u_edge (
		.ref_clk(ref_clk),
		.srst(srst),
		.ce(ce),
		.level(ext_clk_in),
		.rise(ext_rise)
	);

	// one instruction cycle is four clocks; no phases run in sleep
	assign inst_tick = ~sleep_mode & (st_ff.qphase == STC_QPHASE_LAST);

	// in sleep only the unsynchronised external path keeps counting
	assign src_allowed = ~sleep_mode
		| (st_ff.ctrl[STC_CTL_SRC] & st_ff.ctrl[STC_CTL_ASYNC]);
	assign src_tick = st_ff.ctrl[STC_CTL_SRC] ? ext_rise : inst_tick;
	assign pre_in = st_ff.ctrl[STC_CTL_RUN] & src_allowed & src_tick;

	stc_prescaler u_pre (
		.ref_clk(ref_clk),
		.srst(srst),
		.ce(ce),
		.ratio(st_ff.ctrl[STC_CTL_PRE_LO +: 2]),
		.clear(wr_cnt),
		.tick_in(pre_in),
		.tick_out(pre_tick)
	);

	// -----------------------------------------------------------------
	// counter arithmetic
	// -----------------------------------------------------------------
	assign ccp_reset = ccp_a_reset | ccp_b_reset;
	assign cnt_now = {st_ff.cnt_hi, st_ff.cnt_lo};
	assign cnt_inc = cnt_now + 16'h0001;
	// a software write or a unit reset in the same cycle eats the tick
	assign ovf_event = pre_tick & ~wr_cnt & ~ccp_reset
		& (cnt_now == STC_COUNT_MAX);

	// the earlier variant leaves line zero to software
	assign force_mask = LATE_VARIANT ? STC_LATE_FORCE : STC_EARLY_FORCE;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;

		// instruction-cycle phase
		nxt_st.qphase = sleep_mode ? 2'h0 : st_ff.qphase + 2'h1;

		// counter: write wins, then unit reset, then increment
		if (wr_cnt) begin
			if (wr_lo) begin
				nxt_st.cnt_lo = wbyte;
			end
			if (wr_hi) begin
				nxt_st.cnt_hi = wbyte;
			end
		end else if (ccp_reset) begin
			nxt_st.cnt_hi = STC_COUNT_RST;
			nxt_st.cnt_lo = STC_COUNT_RST;
		end else if (pre_tick) begin
			nxt_st.cnt_hi = cnt_inc[15:8];
			nxt_st.cnt_lo = cnt_inc[7:0];
		end

		// overflow flag: read clears only a bit that was seen set
		if (acc_phase & apb_req.pwrite & apb_req.pstrb[0]
			& (acc_sel == STC_SEL_FLAG)) begin
			nxt_st.ovf_flag = wbyte[STC_FLAG_OVF];
		end else if (rd_flag & st_ff.rdata[STC_FLAG_OVF]) begin
			nxt_st.ovf_flag = 1'b0;
		end
		if (ovf_event) begin
			nxt_st.ovf_flag = 1'b1;
		end

		// plain control registers
		if (acc_phase & apb_req.pwrite & apb_req.pstrb[0]) begin
			if (acc_sel == STC_SEL_IE) begin
				nxt_st.ovf_ie = wbyte[STC_IE_OVF];
			end else if (acc_sel == STC_SEL_CTL) begin
				nxt_st.ctrl = wbyte;
			end else if (acc_sel == STC_SEL_DIR) begin
				nxt_st.dir = wbyte;
			end
		end

		// effective port direction follows next register values
		if (nxt_st.ctrl[STC_CTL_OSC]) begin
			nxt_st.dir_eff = nxt_st.dir | force_mask;
		end else begin
			nxt_st.dir_eff = nxt_st.dir;
		end

		// read data is captured in setup, shown in access
		if (setup_phase) begin
			nxt_st.rdata = 32'h0000_0000;
			nxt_st.rd_err = 1'b0;
			case (setup_sel)
				STC_SEL_LOW: begin
					nxt_st.rdata[7:0] = st_ff.cnt_lo;
				end
				STC_SEL_HIGH: begin
					nxt_st.rdata[7:0] = st_ff.cnt_hi;
				end
				STC_SEL_FLAG: begin
					nxt_st.rdata[STC_FLAG_OVF] = st_ff.ovf_flag | ovf_event;
				end
				STC_SEL_IE: begin
					nxt_st.rdata[STC_IE_OVF] = st_ff.ovf_ie;
				end
				STC_SEL_CTL: begin
					nxt_st.rdata[7:0] = st_ff.ctrl;
				end
				STC_SEL_DIR: begin
					nxt_st.rdata[7:0] = st_ff.dir;
				end
				STC_SEL_EFF: begin
					nxt_st.rdata[7:0] = st_ff.dir_eff;
				end
				default: begin
					nxt_st.rd_err = 1'b1;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_ff.cnt_hi <= STC_COUNT_RST;
			st_ff.cnt_lo <= STC_COUNT_RST;
			st_ff.ovf_flag <= 1'b0;
			st_ff.ovf_ie <= 1'b0;
			st_ff.ctrl <= STC_CONTROL_RST;
			st_ff.dir <= STC_PORT_DIR_RST;
			st_ff.dir_eff <= STC_PORT_DIR_RST;
			st_ff.qphase <= 2'h0;
			st_ff.rdata <= 32'h0000_0000;
			st_ff.rd_err <= 1'b0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign irq = st_ff.ovf_flag & st_ff.ovf_ie;
	// synchronous modes have no clock in sleep, so cannot wake
	assign wake_req = sleep_mode & irq & st_ff.ctrl[STC_CTL_SRC]
		& st_ff.ctrl[STC_CTL_ASYNC];
	assign count_value = cnt_now;
	assign port_c_dir_eff = st_ff.dir_eff;

endmodule : stc_timer
`default_nettype wire

/* File: dv/stc_ext_src.sv */
// partner: external count source feeding the timer's count input
`timescale 1ns/10ps
`default_nettype none
module stc_ext_src (
	// clock
	input wire logic ref_clk,
	// command
	input wire logic start,
	input wire logic [7:0] n_edges,
	input wire logic slow,
	// count line and status
	output logic ext_clk,
	output logic busy
);
	int left;
	int ph;
	initial begin
		ext_clk = 1'b0;
		left = 0;
		ph = 0;
	end
	assign busy = (left > 0);
	// line rests low between bursts so no stray edge is counted
	always @(posedge ref_clk) begin
		if (start) begin
			left = n_edges;
			ph = 0;
		end else if (left > 0) begin
			ph = ph + 1;
			if (ph >= (slow ? 4 : 1)) begin
				ph = 0;
				if (ext_clk) begin
					left = left - 1;
				end
				ext_clk <= ~ext_clk; // one rising edge per pulse
			end
		end
	end
endmodule : stc_ext_src
`default_nettype wire

/* File: dv/stc_timer_sva.sv */
// checker: port-level assertions for the timer block
`timescale 1ns/10ps
`default_nettype none
module stc_timer_sva import stc_pkg::*; #(
	parameter bit LATE_VARIANT = 1'b1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// bus
	input wire stc_apb_req_t apb_req,
	input wire stc_apb_rsp_t apb_rsp,
	// side inputs
	input wire logic ext_clk_in,
	input wire logic sleep_mode,
	input wire logic ccp_a_reset,
	input wire logic ccp_b_reset,
	// outputs
	input wire logic irq,
	input wire logic wake_req,
	input wire logic [15:0] count_value,
	input wire logic [7:0] port_c_dir_eff
);
	logic acc;
	logic cnt_wr;
	logic wr_lo;
	logic wr_hi;
	logic swirq;
	logic [7:0] wd;
	assign acc = apb_req.psel & apb_req.penable & ce;
	assign wr_lo = acc & apb_req.pwrite & apb_req.pstrb[0]
		& (apb_req.paddr == STC_ADDR_COUNT_LOW);
	assign wr_hi = acc & apb_req.pwrite & apb_req.pstrb[0]
		& (apb_req.paddr == STC_ADDR_COUNT_HIGH);
	assign cnt_wr = wr_lo | wr_hi;
	// flag and enable accesses are the only legal ways to drop irq
	assign swirq = acc & (apb_req.paddr == STC_ADDR_FLAG
		| apb_req.paddr == STC_ADDR_ENABLE);
	assign wd = apb_req.pwdata[7:0];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_count_step: assert property (ce && !cnt_wr && !ccp_a_reset
		&& !ccp_b_reset |=> count_value == $past(count_value)
		|| count_value == $past(count_value) + 16'h1)
		else $error("count moved other than by one");
	a_ce_freeze: assert property (!ce |=> $stable(count_value))
		else $error("count moved while frozen");
	a_ccp_zero: assert property (ce && !cnt_wr
		&& (ccp_a_reset || ccp_b_reset) |=> count_value == 16'h0)
		else $error("capture reset did not clear count");
	a_wr_low: assert property (wr_lo |=> count_value[7:0] == $past(wd))
		else $error("low count byte not written");
	a_wr_high: assert property (wr_hi |=> count_value[15:8] == $past(wd))
		else $error("high count byte not written");
	a_irq_sticky: assert property (irq && !swirq && ce |=> irq)
		else $error("interrupt dropped without software");
	a_wake_gate: assert property (wake_req |-> sleep_mode && irq)
		else $error("wake request without sleeping interrupt");
	a_ro_error: assert property (acc && apb_req.pwrite
		&& apb_req.paddr == STC_ADDR_PORT_EFF |-> apb_rsp.pslverr)
		else $error("write to read-only place not refused");
	a_ready_ce: assert property (apb_rsp.pready == ce)
		else $error("ready does not follow enable");
	a_rdata_top: assert property (apb_rsp.prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule : stc_timer_sva
bind stc_timer stc_timer_sva #(.LATE_VARIANT(LATE_VARIANT)) u_stc_timer_sva (
	.ref_clk(ref_clk), .srst(srst), .ce(ce), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .ext_clk_in(ext_clk_in), .sleep_mode(sleep_mode),
	.ccp_a_reset(ccp_a_reset), .ccp_b_reset(ccp_b_reset), .irq(irq),
	.wake_req(wake_req), .count_value(count_value),
	.port_c_dir_eff(port_c_dir_eff));
`default_nettype wire

/* File: dv/tb_top.sv */
// testbench: registers, counting, overflow and resets of the timer
`timescale 1ns/10ps
`default_nettype none
module tb_top import stc_pkg::*; ;
	logic ref_clk, srst, ce, sleep_mode, ccp_a, ccp_b, go, slow, err;
	logic irq, wake, ext_clk, busy;
	logic [7:0] ext_n, dir_eff;
	logic [15:0] cnt;
	logic [31:0] rd;
	stc_apb_req_t req;
	stc_apb_rsp_t rsp;
	int miscompares, compares, n, m_lo, m_hi, m_cnt;
	stc_timer u_stc_timer (.ref_clk(ref_clk), .srst(srst), .ce(ce),
		.apb_req(req), .apb_rsp(rsp), .ext_clk_in(ext_clk),
		.sleep_mode(sleep_mode), .ccp_a_reset(ccp_a), .ccp_b_reset(ccp_b),
		.irq(irq), .wake_req(wake), .count_value(cnt),
		.port_c_dir_eff(dir_eff));
	stc_ext_src u_stc_ext_src (.ref_clk(ref_clk), .start(go),
		.n_edges(ext_n), .slow(slow), .ext_clk(ext_clk), .busy(busy));
	task automatic wrap_up();
		if (miscompares == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic stall();
		miscompares++;
		$display("[ERR] %0t wait ran out", $time);
		wrap_up();
	endtask : stall
	// setup one edge, then access until ready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d,
			pstrb:4'h1};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (rsp.pready !== 1'b1 && k < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (rsp.pready !== 1'b1) stall();
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc
	// cycles between two successive count changes
	task automatic gap(output int g);
		logic [15:0] v;
		for (int j = 0; j < 2; j++) begin
			v = cnt;
			g = 0;
			do begin
				@(negedge ref_clk);
				g++;
			end while (cnt === v && g < 100);
		end
		if (g >= 100) stall();
	endtask : gap
	task automatic pulses(input int p, input logic s);
		int k;
		ext_n <= 8'(p);
		slow <= s;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
		k = 0;
		while (busy && k < 200) begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 200) stall();
		repeat (3) @(posedge ref_clk);
	endtask : pulses
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		{srst, ce} = 2'b11;
		{sleep_mode, ccp_a, ccp_b, go, slow, err} = '0;
		req = '0;
		ext_n = 8'h00;
		miscompares = 0;
		compares = 0;
		void'($urandom(73));
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		// ---------------------------------------------------------
		// reset values and refused address
		// ---------------------------------------------------------
		rdc(STC_ADDR_CONTROL, 32'h0);
		rdc(STC_ADDR_PORT_DIR, 32'hff);
		rdc(STC_ADDR_COUNT_HIGH, 32'h0);
		rdc(STC_ADDR_FLAG, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, err}, 32'h1);
		// ---------------------------------------------------------
		// stopped counter keeps written bytes
		// ---------------------------------------------------------
		for (int i = 0; i < 4; i++) begin
			m_lo = $urandom_range(255);
			m_hi = $urandom_range(255);
			apb(1'b1, STC_ADDR_COUNT_LOW, 32'(m_lo));
			apb(1'b1, STC_ADDR_COUNT_HIGH, 32'(m_hi));
			repeat (10) @(posedge ref_clk);
			rdc(STC_ADDR_COUNT_LOW, 32'(m_lo));
			rdc(STC_ADDR_COUNT_HIGH, 32'(m_hi));
			chk({16'h0, cnt}, 32'(m_hi * 256 + m_lo));
		end
		// ---------------------------------------------------------
		// timer mode, every prescale ratio
		// ---------------------------------------------------------
		for (int ps = 0; ps < 4; ps++) begin
			apb(1'b1, STC_ADDR_CONTROL, 32'h0);
			apb(1'b1, STC_ADDR_COUNT_LOW, 32'h0);
			apb(1'b1, STC_ADDR_CONTROL, 32'(1 + ps * 16));
			gap(n);
			chk(32'(n), 32'(4 << ps));
		end
		// enable low freezes a running count
		@(posedge ref_clk);
		ce <= 1'b0;
		@(negedge ref_clk);
		m_cnt = cnt;
		repeat (40) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({16'h0, cnt}, 32'(m_cnt));
		@(posedge ref_clk);
		ce <= 1'b1;
		// ---------------------------------------------------------
		// wrap, flag and interrupt gating
		// ---------------------------------------------------------
		apb(1'b1, STC_ADDR_CONTROL, 32'h0);
		apb(1'b1, STC_ADDR_ENABLE, 32'h1);
		apb(1'b1, STC_ADDR_COUNT_LOW, 32'hfe);
		apb(1'b1, STC_ADDR_COUNT_HIGH, 32'hff);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, STC_ADDR_CONTROL, 32'h1);
		n = 0;
		while (cnt !== 16'h0 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 100) stall();
		@(negedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, STC_ADDR_CONTROL, 32'h0);
		repeat (8) @(posedge ref_clk);
		apb(1'b1, STC_ADDR_ENABLE, 32'h0);
		@(negedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		rdc(STC_ADDR_FLAG, 32'h1);
		rdc(STC_ADDR_FLAG, 32'h0);
		// ---------------------------------------------------------
		// counter mode, prompt and slow source
		// ---------------------------------------------------------
		apb(1'b1, STC_ADDR_COUNT_LOW, 32'h0);
		apb(1'b1, STC_ADDR_COUNT_HIGH, 32'h0);
		apb(1'b1, STC_ADDR_CONTROL, 32'h3);
		m_cnt = 0;
		for (int s = 0; s < 2; s++) begin
			n = $urandom_range(12, 3);
			pulses(n, s[0]);
			m_cnt += n;
			chk({16'h0, cnt}, 32'(m_cnt));
		end
		// ---------------------------------------------------------
		// asynchronous count wakes from power-down
		// ---------------------------------------------------------
		apb(1'b1, STC_ADDR_CONTROL, 32'h0);
		apb(1'b1, STC_ADDR_COUNT_LOW, 32'hff);
		apb(1'b1, STC_ADDR_COUNT_HIGH, 32'hff);
		apb(1'b1, STC_ADDR_ENABLE, 32'h1);
		apb(1'b1, STC_ADDR_CONTROL, 32'h7);
		sleep_mode <= 1'b1;
		pulses(1, 1'b0);
		chk({31'h0, wake}, 32'h1);
		sleep_mode <= 1'b0;
		rdc(STC_ADDR_FLAG, 32'h1);
		// ---------------------------------------------------------
		// capture/compare resets, oscillator pins
		// ---------------------------------------------------------
		apb(1'b1, STC_ADDR_CONTROL, 32'h0);
		for (int u = 1; u < 3; u++) begin
			apb(1'b1, STC_ADDR_COUNT_HIGH, 32'h5a);
			{ccp_b, ccp_a} <= 2'(u);
			@(posedge ref_clk);
			{ccp_b, ccp_a} <= 2'b00;
			@(negedge ref_clk);
			chk({16'h0, cnt}, 32'h0);
		end
		// mid-run reset brings control and pins back
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		rdc(STC_ADDR_CONTROL, 32'h0);
		rdc(STC_ADDR_PORT_EFF, 32'hff);
		apb(1'b1, STC_ADDR_PORT_DIR, 32'h0);
		apb(1'b1, STC_ADDR_CONTROL, 32'h8);
		rdc(STC_ADDR_PORT_EFF, 32'(STC_LATE_FORCE));
		chk({24'h0, dir_eff}, 32'(STC_LATE_FORCE));
		// software still sets line zero as input, as older parts need
		apb(1'b1, STC_ADDR_PORT_DIR, 32'h1);
		rdc(STC_ADDR_PORT_EFF, 32'(STC_LATE_FORCE));
		apb(1'b1, STC_ADDR_PORT_EFF, 32'h0);
		chk({31'h0, err}, 32'h1);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
